/* File: hdl/spi_flash_front.sv */
`timescale 1ns/100ps
module spi_flash_front #(
  parameter int BUSY_PROG_CYC  = flash_pkg::PROG_CYC,
  parameter int BUSY_SECT_CYC  = flash_pkg::SECT_CYC,
  parameter int BUSY_BLOCK_CYC = flash_pkg::BLOCK_CYC,
  parameter int BUSY_CHIP_CYC  = flash_pkg::CHIP_CYC
) (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  // Serial pins
  input  wire logic                          cs_n_i,
  input  wire logic                          sck_i,
  input  wire logic                          si_i,
  input  wire logic                          hold_n_i,
  input  wire logic                          wp_n_i,
  output logic                               so_o,
  output logic                               so_oe_n_o,
  // Array operation request
  output logic                               op_start_o,
  output logic [7:0]                         op_code_o,
  output logic [flash_pkg::ARRAY_AW-1:0]     op_addr_o,
  // Status view
  output logic [7:0]                         status_o
);
  import flash_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;

  pin_sync #(
    .WIDTH   (5),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .clk_i (ref_clk_i),
    .rst_i (rst_i),
    .d_i   ({cs_n_i, sck_i, si_i, hold_n_i, wp_n_i}),
    .q_o   (pins_s)
  );

  wire logic cs_n_s   = pins_s[4];
  wire logic sck_s    = pins_s[3];
  wire logic si_s     = pins_s[2];
  wire logic hold_n_s = pins_s[1];
  wire logic wp_n_s   = pins_s[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cmd_state_t            state_q;
  cmd_state_t            state_d;
  cmd_state_t            first_state;
  logic                  sck_prev_q;
  logic                  hold_prev_q;
  logic                  cs_prev_q;
  logic                  hold_q;
  logic                  hold_d;
  logic [2:0]            bit_cnt_q;
  logic [6:0]            shift_q;
  logic [7:0]            opcode_q;
  logic [23:0]           addr_q;
  logic [1:0]            addr_cnt_q;
  logic                  data_seen_q;
  logic [7:0]            wr_data_q;
  logic                  wel_q;
  logic                  busy_q;
  logic [BUSY_W-1:0]     busy_cnt_q;
  logic [4:0]            nv_q = NV_INIT;
  logic [7:0]            snap_q;
  logic                  stream_drv_q;
  logic                  so_q;
  logic                  so_oe_n_q;
  logic                  op_start_q;
  logic [7:0]            op_code_q;
  logic [ARRAY_AW-1:0]   op_addr_q;
  logic [7:0]            status_q;

  // ----------------------------------------------------------------
  // Clock edges and pause
  // ----------------------------------------------------------------
  // Edges are gated by pause, so clock toggling while held is ignored
  wire logic sck_rise = sck_s & ~sck_prev_q & ~cs_n_s & ~hold_q;
  wire logic sck_fall = ~sck_s & sck_prev_q & ~cs_n_s & ~hold_q;
  wire logic cs_rise  = cs_n_s & ~cs_prev_q;
  // Pause only counts while selected, so a deselected hold is moot
  wire logic hold_enter = ~cs_n_s & ~hold_n_s & hold_prev_q & ~sck_s;
  wire logic hold_leave = hold_n_s & ~hold_prev_q & ~sck_s;

  always_comb begin
    hold_d = hold_q;
    if (cs_n_s) begin
      hold_d = 1'b0;
    end else if (hold_enter) begin
      hold_d = 1'b1;
    end else if (hold_leave) begin
      hold_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sck_prev_q  <= 1'b0;
      hold_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
      hold_q      <= 1'b0;
    end else begin
      sck_prev_q  <= sck_s;
      hold_prev_q <= hold_n_s;
      cs_prev_q   <= cs_n_s;
      hold_q      <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire logic [7:0] rx_byte   = {shift_q, si_s};
  wire logic       byte_done = sck_rise && bit_cnt_q == BIT_LAST;
  wire logic       rx_sect   = rx_byte == OP_SECT_A || rx_byte == OP_SECT_B;
  wire logic       rx_chip   = rx_byte == OP_CHIP_A || rx_byte == OP_CHIP_B;
  wire logic       rx_addr   = rx_sect || rx_byte == OP_PROG ||
                               rx_byte == OP_BLOCK;
  // Frames other than status read taken while busy keep a null opcode, so deselect runs nothing
  wire logic       rx_drop   = busy_q && rx_byte != OP_STATUS_READ_CMD;
  wire logic [7:0] rx_keep   = rx_drop ? 8'h00 : rx_byte;

  // Unknown opcodes park in ST_DONE with no action on deselect
  assign first_state =
    rx_drop                        ? ST_DONE :
    (rx_byte == OP_STATUS_READ_CMD)           ? ST_STREAM :
    (rx_byte == OP_STATUS_WRITE_CMD)           ? ST_DATA :
    rx_addr                        ? ST_ADDR : ST_DONE;

  always_comb begin
    state_d = state_q;
    if (cs_n_s) begin
      state_d = ST_OPCODE;
    end else if (byte_done) begin
      unique case (state_q)
        ST_OPCODE: state_d = first_state;
        ST_ADDR: begin
          if (addr_cnt_q == ADDR_LAST) begin
            state_d = (opcode_q == OP_PROG) ? ST_DATA : ST_DONE;
          end
        end
        ST_DATA: begin
          if (opcode_q == OP_STATUS_WRITE_CMD) begin
            state_d = ST_DONE;
          end
        end
        ST_DONE, ST_STREAM: state_d = state_q;
      endcase
    end
  end

  // Serial shifter; frozen under pause as the edges are gated
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || cs_n_s) begin
      state_q     <= ST_OPCODE;
      bit_cnt_q   <= 3'h0;
      addr_cnt_q  <= 2'h0;
      data_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (sck_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (byte_done && state_q == ST_ADDR) begin
        addr_cnt_q <= addr_cnt_q + 2'h1;
      end
      if (byte_done && state_q == ST_DATA) begin
        data_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_q   <= 7'h00;
      opcode_q  <= 8'h00;
      addr_q    <= 24'h00_0000;
      wr_data_q <= 8'h00;
    end else begin
      if (sck_rise) begin
        shift_q <= rx_byte[6:0];
      end
      if (byte_done && state_q == ST_OPCODE) begin
        opcode_q <= rx_keep;
      end
      if (byte_done && state_q == ST_ADDR) begin
        addr_q <= {addr_q[15:0], rx_byte};
      end
      if (byte_done && state_q == ST_DATA && !data_seen_q) begin
        wr_data_q <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Execution on deselect
  // ----------------------------------------------------------------
  prot_if u_prot_if ();

  assign u_prot_if.addr = addr_q[ARRAY_AW-1:0];
  assign u_prot_if.size = nv_q[2:0];
  assign u_prot_if.tb   = nv_q[NV_TB];

  prot_decode u_prot (
    .p (u_prot_if)
  );

  // A partial byte at deselect aborts, as does a pause
  wire logic run_cmd = cs_rise && !hold_q && bit_cnt_q == 3'h0 &&
                       (state_q == ST_DONE ||
                        (state_q == ST_DATA && opcode_q == OP_PROG &&
                         data_seen_q));
  wire logic op_chip  = opcode_q == OP_CHIP_A || opcode_q == OP_CHIP_B;
  wire logic op_sect  = opcode_q == OP_SECT_A || opcode_q == OP_SECT_B;
  wire logic op_mem   = op_chip || op_sect || opcode_q == OP_PROG ||
                        opcode_q == OP_BLOCK;
  wire logic op_ready = (op_chip && !rx_chip) || op_chip ||
                        addr_cnt_q == 2'h3;
  wire logic chip_blk = op_chip && nv_q[NV_TB:0] != 4'h0;
  wire logic addr_blk = !op_chip && u_prot_if.hit;
  wire logic start_op = run_cmd && op_mem && op_ready && wel_q &&
                        !chip_blk && !addr_blk;
  // Pin high disables the lock entirely
  wire logic status_write_cmd_ok  = run_cmd && opcode_q == OP_STATUS_WRITE_CMD && wel_q &&
                        (wp_n_s || !nv_q[NV_LOCK]);
  wire logic run_write_enable_cmd = run_cmd && opcode_q == OP_WRITE_ENABLE_CMD;
  wire logic run_write_disable_cmd = run_cmd && opcode_q == OP_WRITE_DISABLE_CMD;
  wire logic [4:0] nv_wr = {wr_data_q[SR_LOCK], wr_data_q[SR_TB],
                            wr_data_q[SR_BP2:SR_BP0]};
  wire logic [BUSY_W-1:0] busy_load =
    (opcode_q == OP_PROG) ? BUSY_W'(BUSY_PROG_CYC - 1) :
    op_sect               ? BUSY_W'(BUSY_SECT_CYC - 1) :
    op_chip               ? BUSY_W'(BUSY_CHIP_CYC - 1) :
                            BUSY_W'(BUSY_BLOCK_CYC - 1);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wel_q <= 1'b0;
    end else if (run_write_enable_cmd) begin
      wel_q <= 1'b1;
    end else if (run_write_disable_cmd || start_op || status_write_cmd_ok) begin
      wel_q <= 1'b0;
    end
  end

  // Not cleared by reset: models cells that keep their content
  always_ff @(posedge ref_clk_i) begin
    if (status_write_cmd_ok) begin
      nv_q <= nv_wr;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end else if (start_op) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= busy_load;
    end else if (busy_q) begin
      busy_q     <= busy_cnt_q != '0;
      busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      op_start_q <= 1'b0;
      op_code_q  <= 8'h00;
      op_addr_q  <= '0;
    end else begin
      op_start_q <= start_op;
      if (start_op) begin
        op_code_q <= opcode_q;
        op_addr_q <= addr_q[ARRAY_AW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and serial output
  // ----------------------------------------------------------------
  wire logic [7:0] status_now = {nv_q[NV_LOCK], 1'b0, nv_q[NV_TB],
                                 nv_q[2:0], wel_q, busy_q};

  wire logic stream_drv_d = !cs_n_s && state_q == ST_STREAM &&
                            (stream_drv_q || sck_fall);

  // Byte is snapped at its first bit so busy cannot tear mid-byte
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      snap_q       <= 8'h00;
      so_q         <= 1'b0;
      stream_drv_q <= 1'b0;
      so_oe_n_q    <= 1'b1;
      status_q     <= 8'h00;
    end else begin
      stream_drv_q <= stream_drv_d;
      so_oe_n_q    <= !(stream_drv_d && !hold_d);
      status_q     <= status_now;
      if (sck_fall && state_q == ST_STREAM) begin
        if (bit_cnt_q == 3'h0) begin
          snap_q <= status_now;
          so_q   <= status_now[7];
        end else begin
          so_q <= snap_q[~bit_cnt_q];
        end
      end
    end
  end

  assign so_o       = so_q;
  assign so_oe_n_o  = so_oe_n_q;
  assign op_start_o = op_start_q;
  assign op_code_o  = op_code_q;
  assign op_addr_o  = op_addr_q;
  assign status_o   = status_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_write_enable_cmd_run;
    run_write_enable_cmd;
  endsequence
  sequence s_locked_status_write_cmd;
    run_cmd && opcode_q == OP_STATUS_WRITE_CMD && !wp_n_s && nv_q[NV_LOCK];
  endsequence

  property p_hold_float;
    hold_q |-> so_oe_n_o;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("output driven during pause");

  property p_hold_freeze;
    hold_q && !cs_n_s |=> $stable(bit_cnt_q) && $stable(state_q);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("shifter moved during pause");

  property p_hold_enter;
    hold_enter |=> hold_q;
  endproperty
  a_hold_enter: assert property (p_hold_enter)
    else $error("pause not entered");

  property p_deselect;
    cs_n_s |=> state_q == ST_OPCODE && !hold_q;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect did not return to standby");

  property p_locked;
    s_locked_status_write_cmd |=> $stable(nv_q) && $stable(wel_q);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked status write changed status");

  property p_no_wel;
    run_cmd && op_mem && !wel_q |=> !op_start_o;
  endproperty
  a_no_wel: assert property (p_no_wel)
    else $error("write op started without write enable");

  property p_chip_guard;
    run_cmd && op_chip && nv_q[NV_TB:0] != 4'h0 |=> !op_start_o;
  endproperty
  a_chip_guard: assert property (p_chip_guard)
    else $error("chip erase ran while protected");

  property p_start_busy;
    op_start_o |-> busy_q && !wel_q ##1 status_o[0] && !status_o[1];
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy or write enable wrong after start");

  property p_busy_gate;
    busy_q && byte_done && state_q == ST_OPCODE && rx_byte != OP_STATUS_READ_CMD
      |=> state_q == ST_DONE ##1 !op_start_o;
  endproperty
  a_busy_gate: assert property (p_busy_gate)
    else $error("command accepted while busy");

  property p_write_enable_cmd;
    s_write_enable_cmd_run |=> wel_q ##1 status_o[1];
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd)
    else $error("write enable not latched");

  property p_so_edge;
    !so_oe_n_o && $changed(so_o) |-> $past(sck_fall);
  endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("output changed without falling clock");

  property p_busy_drop;
    run_cmd && busy_q |=> $stable(wel_q) && $stable(nv_q);
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("command ran while busy");
endmodule

/* File: shared/flash_pkg.sv */
package flash_pkg;

  // ----------------------------------------------------------------
  // Clock and busy timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 40;
  localparam int T_PROG_NS    = 10_000;
  localparam int T_SECT_NS    = 40_000;
  localparam int T_BLOCK_NS   = 60_000;
  localparam int T_CHIP_NS    = 80_000;
  localparam int PROG_CYC     = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int SECT_CYC     = (T_SECT_NS * CLK_MHZ + 999) / 1000;
  localparam int BLOCK_CYC    = (T_BLOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int CHIP_CYC     = (T_CHIP_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_W       = 16;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE_CMD   = 8'h01;
  localparam logic [7:0] OP_PROG   = 8'h02;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD   = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD   = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_SECT_A = 8'h20;
  localparam logic [7:0] OP_SECT_B = 8'hd7;
  localparam logic [7:0] OP_BLOCK  = 8'hd8;
  localparam logic [7:0] OP_CHIP_A = 8'h60;
  localparam logic [7:0] OP_CHIP_B = 8'hc7;

  // ----------------------------------------------------------------
  // Status register fields and stored protection bits
  // ----------------------------------------------------------------
  localparam int SR_BP0  = 2;
  localparam int SR_BP2  = 4;
  localparam int SR_TB   = 5;
  localparam int SR_LOCK = 7;
  localparam int NV_TB   = 3;
  localparam int NV_LOCK = 4;
  localparam logic [4:0] NV_INIT = 5'h00;

  // ----------------------------------------------------------------
  // Array geometry and framing
  // ----------------------------------------------------------------
  localparam int ARRAY_AW     = 20;
  localparam int PROT_UNIT_AW = 16;
  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_ALL  = 3'h5;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  // Pin order: cs_n, sck, si, hold_n, wp_n
  localparam logic [4:0] PIN_IDLE  = 5'h13;

  typedef enum logic [4:0] {
    ST_OPCODE = 5'h01,
    ST_ADDR   = 5'h02,
    ST_DATA   = 5'h04,
    ST_DONE   = 5'h08,
    ST_STREAM = 5'h10
  } cmd_state_t;

endpackage

/* File: shared/prot_if.sv */
`timescale 1ns/100ps
interface prot_if;
  logic [flash_pkg::ARRAY_AW-1:0] addr;
  logic [2:0]                     size;
  logic                           tb;
  logic                           hit;
  modport req (output addr, output size, output tb, input hit);
  modport dec (input addr, input size, input tb, output hit);
endinterface

/* File: hdl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

/* File: hdl/prot_decode.sv */
`timescale 1ns/100ps
module prot_decode (
  prot_if.dec p
);
  import flash_pkg::*;

  localparam logic [ARRAY_AW:0] UNIT =
    (ARRAY_AW+1)'(1 << PROT_UNIT_AW);
  localparam logic [ARRAY_AW:0] FULL =
    (ARRAY_AW+1)'(1 << ARRAY_AW);

  // Region doubles with each size code: 1/16, 1/8, 1/4, 1/2
  wire logic [ARRAY_AW:0] span     = UNIT << (p.size - 3'h1);
  wire logic [ARRAY_AW:0] addr_ext = {1'b0, p.addr};
  wire logic              top_hit  = addr_ext >= (FULL - span);
  wire logic              bot_hit  = addr_ext < span;

  assign p.hit = (p.size == SIZE_NONE) ? 1'b0 :
                 (p.size >= SIZE_ALL)  ? 1'b1 :
                 p.tb ? bot_hit : top_hit;
endmodule

/* File: tb/spi_host.sv */
`timescale 1ns/100ps
module spi_host (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  logic mode3_q;

  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    si_o     = 1'b0;
    hold_n_o = 1'b1;
    mode3_q  = 1'b0;
  end

  // Half of the 200 ns link period
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  // Clock parks at the idle level of the mode before select falls
  task automatic start(input logic m3);
    mode3_q = m3;
    sck_o   = m3;
    half();
    cs_n_o  = 1'b0;
    half();
  endtask

  // Sampling late in the high phase leaves margin for output latency
  task automatic xbit(input logic b, output logic r);
    sck_o = 1'b0;
    si_o  = b;
    half();
    sck_o = 1'b1;
    half();
    r     = so_i;
  endtask

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) xbit(tx[i], rx[i]);
  endtask

  task automatic stop();
    sck_o  = mode3_q;
    half();
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    half();
  endtask

  // Clock and data keep moving while paused, as a real host may
  task automatic pause(input logic drop, output logic oe_n);
    sck_o    = 1'b0;
    half();
    hold_n_o = 1'b0;
    repeat (2) begin
      half();
      sck_o = 1'b1;
      si_o  = ~si_o;
      half();
      sck_o = 1'b0;
    end
    oe_n = so_oe_n_i;
    if (drop) cs_n_o = 1'b1;
    half();
    hold_n_o = 1'b1;
    half();
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import flash_pkg::*;
  logic                ref_clk, rst, wp_n, cs_n, sck, si, hold_n;
  logic                so, so_oe_n, so_line, op_start, oe;
  logic                wel_m, busy_m, tb_m, lock_m;
  logic [2:0]          size_m;
  logic [7:0]          op_code, status, r, c;
  logic [ARRAY_AW-1:0] op_addr;
  logic [7:0]          tbl [6];
  int                  seed, error_cnt, n_tests, n_start, n_exp;

  spi_flash_front #(.BUSY_PROG_CYC(8), .BUSY_SECT_CYC(8),
    .BUSY_BLOCK_CYC(8)) spi_flash_front_inst (
    .ref_clk_i(ref_clk), .rst_i(rst), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
    .so_oe_n_o(so_oe_n), .op_start_o(op_start), .op_code_o(op_code),
    .op_addr_o(op_addr), .status_o(status));
  spi_host spi_host_inst (.clk_i(ref_clk), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si), .hold_n_o(hold_n), .so_i(so_line), .so_oe_n_i(so_oe_n));

  // A released line shows the inverse of its last level
  assign so_line = so_oe_n ? ~so : so;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (op_start === 1'b1) n_start <= n_start + 1;

  // --------------------------------
  // Checking and expectation helpers
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [7:0] sr_fn();
    return {lock_m, 1'b0, tb_m, size_m, wel_m, busy_m};
  endfunction

  function automatic logic hit_fn(input logic [19:0] a);
    int sh;
    sh = int'(size_m) - 1;
    if (size_m == 3'h0) return 1'b0;
    if (size_m > 3'h4) return 1'b1;
    return (a[19:16] >> sh) == (tb_m ? 4'h0 : 4'hf >> sh);
  endfunction

  task automatic wait_st(input logic v);
    int i;
    for (i = 0; i < 4000 && status[0] !== v; i++) @(negedge ref_clk);
    if (i == 4000) begin
      error_cnt++;
      $display("ERROR %0t busy flag stuck", $time);
      tally_and_finish();
    end
  endtask

  task automatic reset();
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst    = 1'b0;
    wel_m  = 1'b0;
    busy_m = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic rd_chk();
    logic [7:0] b1, b2;
    spi_host_inst.start(1'($random(seed)));
    spi_host_inst.xbyte(OP_STATUS_READ_CMD, b1);
    spi_host_inst.xbyte(8'h00, b1);
    spi_host_inst.xbyte(8'h00, b2);
    spi_host_inst.stop();
    check(32'(b1), 32'(sr_fn()));
    check(32'(b2), 32'(sr_fn()));
  endtask

  // One command frame, then the expected effect on status and array port
  task automatic op(input logic [7:0] k, input logic [31:0] t, input int nb);
    logic        acc;
    logic [19:0] a;
    acc = 1'b0;
    a   = (nb == 4) ? t[27:8] : t[19:0];
    spi_host_inst.start(1'($random(seed)));
    spi_host_inst.xbyte(k, r);
    for (int j = nb - 1; j >= 0; j--) spi_host_inst.xbyte(t[8*j+:8], r);
    spi_host_inst.stop();
    if (!busy_m) begin
      case (k)
        OP_WRITE_ENABLE_CMD: wel_m = 1'b1;
        OP_WRITE_DISABLE_CMD: wel_m = 1'b0;
        OP_STATUS_WRITE_CMD: if (wel_m && (wp_n || !lock_m)) begin
          {lock_m, tb_m, size_m} = {t[7], t[5:2]};
          wel_m = 1'b0;
        end
        OP_CHIP_A, OP_CHIP_B: acc = wel_m && size_m == 3'h0 && !tb_m;
        default: acc = wel_m && !hit_fn(a);
      endcase
    end
    if (acc) begin
      n_exp++;
      wel_m  = 1'b0;
      busy_m = 1'b1;
      wait_st(1'b1);
      check(32'(op_code), 32'(k));
      if (nb > 0) check(32'(op_addr), 32'(a));
    end
    if (nb > 0) begin
      wait_st(1'b0);
      busy_m = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    check(32'(status), 32'(sr_fn()));
    check(32'(n_start), 32'(n_exp));
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    seed = 23841;
    {error_cnt, n_tests, n_start, n_exp} = '0;
    {wel_m, busy_m, tb_m, lock_m, size_m} = '0;
    tbl  = '{OP_STATUS_WRITE_CMD, OP_PROG, OP_WRITE_DISABLE_CMD, OP_SECT_A, OP_SECT_B, OP_BLOCK};
    wp_n = 1'b1;
    reset();
    rd_chk();
    op(OP_PROG, 32'h0001_0000, 4);
    for (int i = 0; i < 30; i++) begin
      c    = tbl[i % 6];
      wp_n = 1'($random(seed));
      op(OP_WRITE_ENABLE_CMD, '0, 0);
      op(c, $random(seed), (c == OP_STATUS_WRITE_CMD) ? 1 :
         (c == OP_PROG) ? 4 : (c == OP_WRITE_DISABLE_CMD) ? 0 : 3);
    end
    // Protection must outlive a reset in mid-run
    reset();
    rd_chk();
    wp_n = 1'b1;
    op(OP_WRITE_ENABLE_CMD, '0, 0);
    op(OP_STATUS_WRITE_CMD, 32'h0000_0024, 1);
    op(OP_WRITE_ENABLE_CMD, '0, 0);
    op(OP_CHIP_A, '0, 0);
    op(OP_STATUS_WRITE_CMD, '0, 1);
    op(OP_WRITE_ENABLE_CMD, '0, 0);
    op(OP_CHIP_B, '0, 0);
    op(OP_WRITE_ENABLE_CMD, '0, 0);
    wait_st(1'b0);
    busy_m = 1'b0;
    op(OP_WRITE_ENABLE_CMD, '0, 0);
    op(OP_STATUS_WRITE_CMD, 32'h0000_00b4, 1);
    wp_n = 1'b0;
    op(OP_WRITE_ENABLE_CMD, '0, 0);
    op(OP_STATUS_WRITE_CMD, '0, 1);
    // Pause in mid-byte; the stream must resume on the same bit
    spi_host_inst.start(1'b0);
    spi_host_inst.xbyte(OP_STATUS_READ_CMD, r);
    for (int k = 7; k >= 0; k--) begin
      if (k == 4) spi_host_inst.pause(1'b0, oe);
      spi_host_inst.xbit(1'b0, r[k]);
    end
    spi_host_inst.stop();
    check(32'(oe), 32'h1);
    check(32'(r), 32'(sr_fn()));
    op(OP_WRITE_DISABLE_CMD, '0, 0);
    spi_host_inst.start(1'b1);
    spi_host_inst.xbyte(OP_WRITE_ENABLE_CMD, r);
    spi_host_inst.pause(1'b1, oe);
    repeat (8) @(negedge ref_clk);
    check(32'(status), 32'(sr_fn()));
    tally_and_finish();
  end
endmodule
